/* File: rtl/fss_suspend_ctrl.sv */
// suspend, resume and software reset sequencer with its register slave
`timescale 1ns/1ps
// Functional notes
// - suspend command halts a running page program, sector or block erase
// - while suspended, reads are refused inside the suspended page, sector or block and, during a nested program, inside its page
// - after suspend latency, write latch clears and the matching suspend flag sets
// - reads, id reads, burst set accepted only after latency; quad io read program-suspend only
// - lock, status reads, interrupt, signature, reset arm/execute, no-op accepted anytime
// - status bit 15 shows suspended program, bit 10 suspended erase
// - resume sets write latch and in-progress, clears the suspend flag at once
// - erase suspend allows page programs outside the suspended erase region
// - nested page program cannot be suspended and must finish before resume
// - nested program keeps latch and in-progress at 1, both clear when done
// - resumed operation runs until done or suspended again
// - no-op only cancels a pending reset arm; upper data lines ignored
// - reset execute works only directly after reset arm; other accepted commands cancel the arm, rejected ones leave it set
// - software reset returns to standby with all status word bits and the reset arm cleared
// - software reset during program or erase aborts that operation
module fss_suspend_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic linkCsN,
    input wire logic linkSclk,
    input wire logic [3:0] linkSioIn,
    output logic [3:0] linkSioOut,
    output logic [3:0] linkSioOe,
    input wire logic opStart,
    input wire fss_pkg::fss_op_req_t opReq,
    input wire logic engineDone,
    output logic engineRun,
    output logic engineAbort,
    output fss_pkg::fss_op_req_t engineOp,
    input wire logic [23:0] chkAddr,
    output logic readAllowed,
    output logic programAllowed,
    output logic cmdAccept,
    output logic cmdReject,
    output logic [7:0] cmdCode,
    output logic softReset,
    output logic [15:0] statusWord,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    import fss_pkg::*;

    logic rxValid;
    logic [7:0] rxByte;
    fss_state_t state_q, state_d;
    fss_op_req_t opQ, nestQ;
    logic writeLatch_q, inProgress_q, pgmSusp_q, eraseSusp_q, arm_q;
    logic [LAT_W-1:0] latCnt_q;
    logic ackQ;
    logic [IRQ_W-1:0] irqStatus_q, irqEnable_q;
    logic ctrlSuspend, ctrlResume;
    logic cmdEv, isSuspendCmd, isResumeCmd, noLat, afterLat, accept;
    logic doSuspend, doResume, doSoftReset, latDone, doStart, doNest, opFinish, nestFinish, startRefused;
    logic opIsErase, busAccess, busWrite;
    logic [IRQ_W-1:0] irqEvent;

    // ****************************************
    // link receiver; data lines 1..3 are never looked at
    // ****************************************
    fss_cmd_rx u_rx (
        .clk(clk),
        .rst_n(rst_n),
        .linkCsN(linkCsN),
        .linkSclk(linkSclk),
        .linkSio0(linkSioIn[0]),
        .cmdValid(rxValid),
        .cmdByte(rxByte)
    );

    assign linkSioOut = 4'h0;
    assign linkSioOe = 4'h0;

    // ****************************************
    // region check helper
    // ****************************************
    function automatic logic inRegion(input fss_op_req_t op, input logic [23:0] a);
        logic [23:0] m;
        m = MASK_PAGE;
        case (op.kind)
            OP_SECTOR_ERASE: m = MASK_SECTOR;
            OP_BLOCK32_ERASE: m = MASK_BLOCK32;
            OP_BLOCK64_ERASE: m = MASK_BLOCK64;
            default: m = MASK_PAGE;
        endcase
        return (a & ~m) == (op.addr & ~m);
    endfunction

    // ****************************************
    // command classification
    // ****************************************
    always_comb begin
        noLat = 1'b0;
        afterLat = 1'b0;
        case (rxByte)
            CMD_WRITE_LOCK, CMD_STATUS_LOW_READ, CMD_STATUS_HIGH_READ, CMD_ACTIVE_STATUS_INT,
            CMD_SIGNATURE_READ, CMD_RESET_ARM, CMD_RESET_EXEC, CMD_NOP: begin
                noLat = 1'b1;
            end
            CMD_READ, CMD_FAST_READ, CMD_DUAL_OUTPUT_READ, CMD_QUAD_OUTPUT_READ, CMD_DUAL_IO_READ,
            CMD_PARAMETER_TABLE_READ, CMD_IDENTIFICATION_READ, CMD_MAKER_DEVICE_ID_READ,
            CMD_DUAL_MAKER_DEVICE_ID_READ, CMD_QUAD_MAKER_DEVICE_ID_READ, CMD_SECURITY_AREA_READ,
            CMD_BURST_LENGTH_SET, CMD_RESUME_A, CMD_RESUME_B: begin
                afterLat = 1'b1;
            end
            CMD_QUAD_IO_READ: begin
                afterLat = pgmSusp_q;
            end
            CMD_WRITE_UNLOCK, CMD_PAGE_PGM, CMD_DUAL_PAGE_PGM, CMD_QUAD_PAGE_PGM: begin
                afterLat = eraseSusp_q;
            end
            default: begin
                afterLat = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (state_q)
            S_SUSP_WAIT, S_NESTED: accept = noLat;
            S_SUSPENDED: accept = noLat | afterLat;
            default: accept = 1'b1;
        endcase
    end

    assign cmdEv = rxValid & accept;
    assign isSuspendCmd = rxByte == CMD_SUSPEND;
    assign isResumeCmd = (rxByte == CMD_RESUME_A) || (rxByte == CMD_RESUME_B);
    assign opIsErase = opQ.kind != OP_PAGE_PGM;

    // ****************************************
    // sequencing events
    // ****************************************
    assign doSoftReset = cmdEv && rxByte == CMD_RESET_EXEC && arm_q;
    assign doSuspend = state_q == S_RUN && ((cmdEv && isSuspendCmd) || ctrlSuspend);
    assign doResume = state_q == S_SUSPENDED && ((cmdEv && isResumeCmd) || ctrlResume);
    assign latDone = state_q == S_SUSP_WAIT && latCnt_q == '0 && !engineDone;
    assign opFinish = engineDone && (state_q == S_RUN || state_q == S_SUSP_WAIT);
    assign nestFinish = engineDone && state_q == S_NESTED;
    assign doStart = opStart && state_q == S_IDLE && writeLatch_q;
    assign doNest = opStart && state_q == S_SUSPENDED && eraseSusp_q && writeLatch_q &&
                    opReq.kind == OP_PAGE_PGM && !inRegion(opQ, opReq.addr);
    assign startRefused = opStart && !doStart && !doNest;

    // ****************************************
    // state machine
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (doStart) begin
                    state_d = S_RUN;
                end
            end
            S_RUN: begin
                if (opFinish) begin
                    state_d = S_IDLE;
                end else if (doSuspend) begin
                    state_d = S_SUSP_WAIT;
                end
            end
            S_SUSP_WAIT: begin
                if (opFinish) begin
                    state_d = S_IDLE;
                end else if (latDone) begin
                    state_d = S_SUSPENDED;
                end
            end
            S_SUSPENDED: begin
                if (doResume) begin
                    state_d = S_RUN;
                end else if (doNest) begin
                    state_d = S_NESTED;
                end
            end
            S_NESTED: begin
                if (nestFinish) begin
                    state_d = S_SUSPENDED;
                end
            end
            default: state_d = S_IDLE;
        endcase
        if (doSoftReset) begin
            state_d = S_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opQ <= '0;
            nestQ <= '0;
        end else begin
            if (doStart) begin
                opQ <= opReq;
            end
            if (doNest) begin
                nestQ <= opReq;
            end
        end
    end

    // ****************************************
    // suspend latency counter
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latCnt_q <= '0;
        end else if (doSuspend) begin
            latCnt_q <= opIsErase ? LAT_W'(ERASE_SUSPEND_LAT_CYC - 1) : LAT_W'(PGM_SUSPEND_LAT_CYC - 1);
        end else if (state_q == S_SUSP_WAIT && latCnt_q != '0) begin
            latCnt_q <= latCnt_q - 1'b1;
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            writeLatch_q <= 1'b0;
            inProgress_q <= 1'b0;
            pgmSusp_q <= 1'b0;
            eraseSusp_q <= 1'b0;
        end else if (doSoftReset) begin
            writeLatch_q <= 1'b0;
            inProgress_q <= 1'b0;
            pgmSusp_q <= 1'b0;
            eraseSusp_q <= 1'b0;
        end else begin
            if (cmdEv && rxByte == CMD_WRITE_UNLOCK && (state_q == S_IDLE || state_q == S_SUSPENDED)) begin
                writeLatch_q <= 1'b1;
            end
            if (cmdEv && rxByte == CMD_WRITE_LOCK && (state_q == S_IDLE || state_q == S_SUSPENDED)) begin
                writeLatch_q <= 1'b0;
            end
            if (doStart || doNest) begin
                inProgress_q <= 1'b1;
            end
            if (latDone) begin
                writeLatch_q <= 1'b0;
                inProgress_q <= 1'b0;
                pgmSusp_q <= !opIsErase;
                eraseSusp_q <= opIsErase;
            end
            if (doResume) begin
                writeLatch_q <= 1'b1;
                inProgress_q <= 1'b1;
                pgmSusp_q <= 1'b0;
                eraseSusp_q <= 1'b0;
            end
            if (opFinish || nestFinish) begin
                writeLatch_q <= 1'b0;
                inProgress_q <= 1'b0;
            end
        end
    end

    assign statusWord = {pgmSusp_q, 4'h0, eraseSusp_q, 8'h00, writeLatch_q, inProgress_q};

    // ****************************************
    // reset arm
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arm_q <= 1'b0;
        end else if (cmdEv) begin
            arm_q <= rxByte == CMD_RESET_ARM && !arm_q;
        end
    end

    // ****************************************
    // engine, command and permission outputs
    // ****************************************
    assign engineRun = state_q == S_RUN || state_q == S_SUSP_WAIT || state_q == S_NESTED;
    assign engineOp = state_q == S_NESTED ? nestQ : opQ;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            engineAbort <= 1'b0;
            softReset <= 1'b0;
            cmdAccept <= 1'b0;
            cmdReject <= 1'b0;
            cmdCode <= 8'h00;
            readAllowed <= 1'b1;
            programAllowed <= 1'b0;
        end else begin
            engineAbort <= doSoftReset && state_q != S_IDLE;
            softReset <= doSoftReset;
            cmdAccept <= cmdEv;
            cmdReject <= (rxValid && !accept) || startRefused;
            if (rxValid) begin
                cmdCode <= rxByte;
            end
            readAllowed <= !((state_q == S_SUSPENDED || state_q == S_NESTED) && inRegion(opQ, chkAddr)) &&
                           !(state_q == S_NESTED && inRegion(nestQ, chkAddr));
            programAllowed <= state_q == S_SUSPENDED && eraseSusp_q && writeLatch_q &&
                              !inRegion(opQ, chkAddr);
        end
    end

    // ****************************************
    // avalon slave: one wait cycle per access
    // ****************************************
    assign busAccess = avs_read | avs_write;
    assign busWrite = avs_write & ackQ;
    assign avs_waitrequest = busAccess & ~ackQ;
    assign ctrlSuspend = busWrite && avs_address == REG_CONTROL && avs_writedata[CTRL_SUSPEND_REQ];
    assign ctrlResume = busWrite && avs_address == REG_CONTROL && avs_writedata[CTRL_RESUME_REQ];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ackQ <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ackQ <= busAccess & ~ackQ;
            if (avs_read && !ackQ) begin
                case (avs_address)
                    REG_FLAGS: avs_readdata <= {16'h0000, statusWord};
                    REG_IRQ_STATUS: avs_readdata <= {27'h0, irqStatus_q};
                    REG_IRQ_ENABLE: avs_readdata <= {27'h0, irqEnable_q};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // interrupts: set wins over clear
    // ****************************************
    always_comb begin
        irqEvent = '0;
        irqEvent[IRQ_SUSPENDED] = latDone;
        irqEvent[IRQ_RESUMED] = doResume;
        irqEvent[IRQ_OP_DONE] = opFinish | nestFinish;
        irqEvent[IRQ_SOFT_RESET] = doSoftReset;
        irqEvent[IRQ_REJECT] = (rxValid & ~accept) | startRefused;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStatus_q <= '0;
            irqEnable_q <= '0;
            irq <= 1'b0;
        end else begin
            if (busWrite && avs_address == REG_IRQ_CLEAR) begin
                irqStatus_q <= (irqStatus_q & ~avs_writedata[IRQ_W-1:0]) | irqEvent;
            end else begin
                irqStatus_q <= irqStatus_q | irqEvent;
            end
            if (busWrite && avs_address == REG_IRQ_ENABLE) begin
                irqEnable_q <= avs_writedata[IRQ_W-1:0];
            end
            irq <= |(irqStatus_q & irqEnable_q);
        end
    end
endmodule

/* File: rtl/fss_pkg.sv */
// constants, command codes and types for the flash suspend/resume sequencer
package fss_pkg;

    // ****************************************
    // clock and latencies
    // ****************************************
    localparam int CLK_MHZ = 125;
    localparam int PGM_SUSPEND_LAT_US = 20;
    localparam int ERASE_SUSPEND_LAT_US = 20;
    localparam int PGM_SUSPEND_LAT_CYC = PGM_SUSPEND_LAT_US * CLK_MHZ;
    localparam int ERASE_SUSPEND_LAT_CYC = ERASE_SUSPEND_LAT_US * CLK_MHZ;
    localparam int LAT_W = 12;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_PAGE_PGM = 8'h02;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_WRITE_LOCK = 8'h04;
    localparam logic [7:0] CMD_STATUS_LOW_READ = 8'h05;
    localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] CMD_FAST_READ = 8'h0B;
    localparam logic [7:0] CMD_ACTIVE_STATUS_INT = 8'h25;
    localparam logic [7:0] CMD_RESUME_B = 8'h30;
    localparam logic [7:0] CMD_QUAD_PAGE_PGM = 8'h32;
    localparam logic [7:0] CMD_STATUS_HIGH_READ = 8'h35;
    localparam logic [7:0] CMD_DUAL_OUTPUT_READ = 8'h3B;
    localparam logic [7:0] CMD_SECURITY_AREA_READ = 8'h48;
    localparam logic [7:0] CMD_PARAMETER_TABLE_READ = 8'h5A;
    localparam logic [7:0] CMD_RESET_ARM = 8'h66;
    localparam logic [7:0] CMD_QUAD_OUTPUT_READ = 8'h6B;
    localparam logic [7:0] CMD_SUSPEND = 8'h75;
    localparam logic [7:0] CMD_BURST_LENGTH_SET = 8'h77;
    localparam logic [7:0] CMD_RESUME_A = 8'h7A;
    localparam logic [7:0] CMD_MAKER_DEVICE_ID_READ = 8'h90;
    localparam logic [7:0] CMD_DUAL_MAKER_DEVICE_ID_READ = 8'h92;
    localparam logic [7:0] CMD_QUAD_MAKER_DEVICE_ID_READ = 8'h94;
    localparam logic [7:0] CMD_RESET_EXEC = 8'h99;
    localparam logic [7:0] CMD_IDENTIFICATION_READ = 8'h9F;
    localparam logic [7:0] CMD_DUAL_PAGE_PGM = 8'hA2;
    localparam logic [7:0] CMD_SIGNATURE_READ = 8'hAB;
    localparam logic [7:0] CMD_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] CMD_QUAD_IO_READ = 8'hEB;

    // ****************************************
    // status word bit positions
    // ****************************************
    localparam int ST_IN_PROGRESS = 0;
    localparam int ST_WRITE_LATCH = 1;
    localparam int ST_ERASE_SUSP = 10;
    localparam int ST_PGM_SUSP = 15;

    // ****************************************
    // operations and protected regions
    // ****************************************
    typedef enum logic [2:0] {
        OP_PAGE_PGM = 3'b000,
        OP_PAGE_ERASE = 3'b001,
        OP_SECTOR_ERASE = 3'b010,
        OP_BLOCK32_ERASE = 3'b011,
        OP_BLOCK64_ERASE = 3'b100
    } fss_op_kind_t;

    typedef struct packed {
        fss_op_kind_t kind;
        logic [23:0] addr;
    } fss_op_req_t;

    localparam logic [23:0] MASK_PAGE = 24'h0000FF;
    localparam logic [23:0] MASK_SECTOR = 24'h000FFF;
    localparam logic [23:0] MASK_BLOCK32 = 24'h007FFF;
    localparam logic [23:0] MASK_BLOCK64 = 24'h00FFFF;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RUN = 3'b001,
        S_SUSP_WAIT = 3'b010,
        S_SUSPENDED = 3'b011,
        S_NESTED = 3'b100
    } fss_state_t;

    // ****************************************
    // register map and interrupt bits
    // ****************************************
    localparam int ADDR_W = 5;
    localparam logic [4:0] REG_FLAGS = 5'h00;
    localparam logic [4:0] REG_IRQ_STATUS = 5'h04;
    localparam logic [4:0] REG_IRQ_CLEAR = 5'h08;
    localparam logic [4:0] REG_IRQ_ENABLE = 5'h0C;
    localparam logic [4:0] REG_CONTROL = 5'h10;
    localparam int CTRL_SUSPEND_REQ = 0;
    localparam int CTRL_RESUME_REQ = 1;

    localparam int IRQ_W = 5;
    localparam int IRQ_SUSPENDED = 0;
    localparam int IRQ_RESUMED = 1;
    localparam int IRQ_OP_DONE = 2;
    localparam int IRQ_SOFT_RESET = 3;
    localparam int IRQ_REJECT = 4;
endpackage

/* File: rtl/fss_cmd_rx.sv */
// pin synchroniser and first-byte command receiver on the serial link
`timescale 1ns/1ps
module fss_cmd_rx (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic linkCsN,
    input wire logic linkSclk,
    input wire logic linkSio0,
    output logic cmdValid,
    output logic [7:0] cmdByte
);
    import fss_pkg::*;

    logic csMeta_q, csSync_q, sclkMeta_q, sclkSync_q, sclkPrev_q, sioMeta_q, sioSync_q;
    logic [2:0] bitCnt_q;
    logic [6:0] shift_q;
    logic gotCmd_q;
    logic sclkRise;

    // ****************************************
    // two-flop synchronisers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csMeta_q <= 1'b1;
            csSync_q <= 1'b1;
            sclkMeta_q <= 1'b0;
            sclkSync_q <= 1'b0;
            sclkPrev_q <= 1'b0;
            sioMeta_q <= 1'b0;
            sioSync_q <= 1'b0;
        end else begin
            csMeta_q <= linkCsN;
            csSync_q <= csMeta_q;
            sclkMeta_q <= linkSclk;
            sclkSync_q <= sclkMeta_q;
            sclkPrev_q <= sclkSync_q;
            sioMeta_q <= linkSio0;
            sioSync_q <= sioMeta_q;
        end
    end

    assign sclkRise = sclkSync_q & ~sclkPrev_q;

    // ****************************************
    // command byte, msb first, only first byte of a frame
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_q <= 3'h0;
            shift_q <= 7'h00;
            gotCmd_q <= 1'b0;
            cmdValid <= 1'b0;
            cmdByte <= 8'h00;
        end else begin
            cmdValid <= 1'b0;
            if (csSync_q) begin
                bitCnt_q <= 3'h0;
                gotCmd_q <= 1'b0;
            end else if (sclkRise && !gotCmd_q) begin
                shift_q <= {shift_q[5:0], sioSync_q};
                bitCnt_q <= bitCnt_q + 3'h1;
                if (bitCnt_q == 3'h7) begin
                    gotCmd_q <= 1'b1;
                    cmdValid <= 1'b1;
                    cmdByte <= {shift_q, sioSync_q};
                end
            end
        end
    end
endmodule

/* File: verification/fss_assertions.sv */
// port checker for the suspend sequencer
`timescale 1ns/1ps
module fss_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmdAccept,
    input wire logic cmdReject,
    input wire logic engineRun,
    input wire logic softReset,
    input wire logic [15:0] statusWord
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence busy_s;
        statusWord[1:0] == 2'b11;
    endsequence
    a_one_kind: assert property (!(statusWord[15] && statusWord[10]))
        else $error("both suspend flags set");
    a_susp_unlatch: assert property ($rose(statusWord[15] || statusWord[10]) |-> statusWord[1:0] == 2'b00)
        else $error("latch kept on suspend");
    a_resume_busy: assert property ($fell(statusWord[15]) |-> busy_s or statusWord == 16'h0000)
        else $error("resume flags wrong");
    a_prog_paused: assert property (statusWord[15] |-> !engineRun)
        else $error("engine runs in program suspend");
    a_nested_busy: assert property (statusWord[10] && engineRun |-> busy_s)
        else $error("nested program flags low");
    a_nested_done: assert property ($fell(statusWord[0]) && statusWord[10] |-> !statusWord[1])
        else $error("latch kept after nested program");
    a_reset_clear: assert property (softReset |-> ##[0:1] statusWord == 16'h0000)
        else $error("flags kept after soft reset");
    a_cmd_single: assert property (!(cmdAccept && cmdReject))
        else $error("accept and reject together");
endmodule
bind fss_suspend_ctrl fss_assertions u_fss_assertions (.clk(clk), .rst_n(rst_n), .cmdAccept(cmdAccept),
    .cmdReject(cmdReject), .engineRun(engineRun), .softReset(softReset), .statusWord(statusWord));

/* File: verification/fss_link_host.sv */
// serial host model sending one command byte per frame
`timescale 1ns/1ps
module fss_link_host (
    input wire logic clk,
    output logic linkCsN,
    output logic linkSclk,
    output logic [3:0] linkSio
);
    initial begin
        linkCsN = 1'b1;
        linkSclk = 1'b0;
        linkSio = 4'h5;
    end
    // sclk stands low outside frames, 64 ns period inside
    task automatic send(input logic [7:0] cmd);
        linkCsN <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            linkSio <= {~linkSio[3:1], cmd[i]};
            repeat (4) @(posedge clk);
            linkSclk <= 1'b1;
            repeat (4) @(posedge clk);
            linkSclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        linkCsN <= 1'b1;
        linkSio <= ~linkSio;
        repeat (12) @(posedge clk);
    endtask
endmodule

/* File: verification/fss_suspend_ctrl_bench.sv */
// self-checking bench for the suspend sequencer
`timescale 1ns/1ps
module fss_suspend_ctrl_bench;
    import fss_pkg::*;
    logic clk = 0, rst_n = 0, csN, sclk, opStart = 0, engineDone = 0;
    logic avsRead = 0, avsWrite = 0, waitReq, readAllowed, progOk, cmdReject, irq;
    logic [3:0] sio;
    logic [4:0] avsAddress = '0;
    logic [15:0] statusWord;
    logic [23:0] chkAddr = '0;
    logic [31:0] avsWdata = '0, avsRdata, d;
    fss_op_req_t opReq = '0;
    int nFail = 0, testsRun = 0, nRej = 0, cyc = 0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (cmdReject === 1'b1) nRej++;
        if (++cyc == 20000) begin
            nFail++;
            testDone();
        end
    end
    fss_link_host u_fss_link_host (.clk(clk), .linkCsN(csN), .linkSclk(sclk), .linkSio(sio));
    fss_suspend_ctrl u_fss_suspend_ctrl (.clk(clk), .rst_n(rst_n), .linkCsN(csN), .linkSclk(sclk),
        .linkSioIn(sio), .linkSioOut(), .linkSioOe(), .opStart(opStart), .opReq(opReq),
        .engineDone(engineDone), .engineRun(), .engineAbort(), .engineOp(), .chkAddr(chkAddr),
        .readAllowed(readAllowed), .programAllowed(progOk), .cmdAccept(), .cmdReject(cmdReject), .cmdCode(),
        .softReset(), .statusWord(statusWord), .avs_address(avsAddress), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_readdata(avsRdata),
        .avs_waitrequest(waitReq), .irq(irq));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nFail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        avsAddress <= a;
        avsWdata <= wd;
        avsRead <= !wr;
        avsWrite <= wr;
        @(posedge clk);
        while (waitReq !== 1'b0) @(posedge clk);
        d = avsRdata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rdChk(input string nm, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, '0);
        check(nm, d, exp);
    endtask
    task automatic snd(input logic [7:0] c);
        u_fss_link_host.send(c);
    endtask
    task automatic op(input fss_op_kind_t k, input logic [23:0] a);
        opReq <= {k, a};
        opStart <= 1'b1;
        @(posedge clk);
        opStart <= 1'b0;
        // two more edges so a reject pulse is counted before any compare
        repeat (2) @(posedge clk);
    endtask
    task automatic finishOp;
        engineDone <= 1'b1;
        @(posedge clk);
        engineDone <= 1'b0;
        @(posedge clk);
    endtask
    task automatic testDone;
        $display("checks %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b1, REG_IRQ_ENABLE, 32'h1F);
        snd(CMD_SUSPEND);
        rdChk("idle suspend", REG_FLAGS, 32'h0);
        snd(CMD_WRITE_UNLOCK);
        op(OP_SECTOR_ERASE, 24'h012345);
        rdChk("erase run", REG_FLAGS, 32'h3);
        snd(CMD_SUSPEND);
        snd(CMD_FAST_READ);
        snd(CMD_STATUS_LOW_READ);
        check("early cmds", nRej, 1);
        repeat (2600) @(posedge clk);
        rdChk("erase susp", REG_FLAGS, 32'h400);
        for (int i = 0; i < 2; i++) begin
            chkAddr <= 24'h012F00 + 24'(i * 256);
            repeat (3) @(posedge clk);
            check("read region", readAllowed, i);
        end
        snd(CMD_QUAD_IO_READ);
        snd(CMD_WRITE_UNLOCK);
        check("program allowed", progOk, 1);
        op(OP_PAGE_PGM, 24'h012100);
        check("quad io and region", nRej, 3);
        snd(CMD_WRITE_UNLOCK);
        op(OP_PAGE_PGM, 24'h020000);
        snd(CMD_SUSPEND);
        rdChk("nested", REG_FLAGS, 32'h403);
        finishOp();
        rdChk("nested done", REG_FLAGS, 32'h400);
        snd(CMD_RESUME_A);
        rdChk("resumed", REG_FLAGS, 32'h3);
        rdChk("irq status", REG_IRQ_STATUS, 32'h17);
        check("irq high", irq, 1);
        bus(1'b1, REG_IRQ_CLEAR, 32'h1F);
        finishOp();
        rdChk("op done", REG_IRQ_STATUS, 32'h4);
        bus(1'b1, REG_IRQ_ENABLE, 32'h0);
        check("irq masked", irq, 0);
        snd(CMD_WRITE_UNLOCK);
        op(OP_PAGE_PGM, 24'h000100);
        bus(1'b1, REG_CONTROL, 32'h1);
        repeat (2600) @(posedge clk);
        rdChk("prog susp", REG_FLAGS, 32'h8000);
        snd(CMD_QUAD_IO_READ);
        snd(CMD_RESET_ARM);
        snd(CMD_NOP);
        snd(CMD_RESET_EXEC);
        check("prog susp cmds", nRej, 4);
        rdChk("disarmed", REG_FLAGS, 32'h8000);
        bus(1'b1, REG_CONTROL, 32'h2);
        rdChk("ctrl resume", REG_FLAGS, 32'h3);
        repeat (100) @(posedge clk);
        bus(1'b1, REG_CONTROL, 32'h1);
        snd(CMD_RESET_ARM);
        snd(CMD_RESET_EXEC);
        rdChk("soft reset", REG_FLAGS, 32'h0);
        rdChk("unmapped", 5'h14, 32'h0);
        testDone();
    end
endmodule
